// >>> include/pxa_pkg.sv
// Register map, field layout and codes for the pixel ALU operand registers
`default_nettype none
package pxa_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_FG_MIX = 8'h48;
    localparam logic [7:0] IDX_BG_MIX = 8'h49;
    localparam logic [7:0] IDX_CMP_COND = 8'h4A;
    localparam logic [7:0] IDX_CMP_VALUE = 8'h4C;
    localparam logic [7:0] IDX_PLANE_MASK = 8'h50;
    localparam logic [7:0] IDX_CARRY_MASK = 8'h54;
    localparam logic [7:0] IDX_FG_COLOUR = 8'h58;
    localparam logic [7:0] IDX_BG_COLOUR = 8'h5C;
    localparam logic [7:0] IDX_DIM_WIDTH = 8'h60;
    localparam logic [7:0] IDX_DIM_HEIGHT = 8'h62;
    localparam logic [7:0] IDX_MASK_ORG_X = 8'h6C;
    localparam logic [7:0] IDX_MASK_ORG_Y = 8'h6E;
    localparam logic [7:0] IDX_SRC_X = 8'h70;
    localparam logic [7:0] IDX_SRC_Y = 8'h72;
    localparam logic [7:0] IDX_DP_CTRL = 8'h80;
    // Decoded address window
    localparam int ADDR_W = 10;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'h0;
    // Datapath control word fields
    localparam int BG_SRC_LSB = 30;
    localparam int FG_SRC_LSB = 28;
    localparam int PIX_SIZE_LSB = 0;
    localparam logic [1:0] SRC_FIXED_COLOUR = 2'h0;
    localparam logic [1:0] SRC_PIXEL_MAP = 2'h2;
    // Compare condition codes
    localparam logic [2:0] CMP_ALWAYS = 3'h0;
    localparam logic [2:0] CMP_GT = 3'h1;
    localparam logic [2:0] CMP_EQ = 3'h2;
    localparam logic [2:0] CMP_LT = 3'h3;
    localparam logic [2:0] CMP_NEVER = 3'h4;
    localparam logic [2:0] CMP_GE = 3'h5;
    localparam logic [2:0] CMP_NE = 3'h6;
    localparam logic [2:0] CMP_LE = 3'h7;
    // Mix codes: 00..0F boolean truth table, then arithmetic
    localparam logic [3:0] MIX_LOGIC_GRP = 4'h0;
    localparam logic [7:0] MIX_ADD = 8'h10;
    localparam logic [7:0] MIX_SUB_DS = 8'h11;
    localparam logic [7:0] MIX_SUB_SD = 8'h12;
    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_HALF = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
endpackage
`default_nettype wire

// >>> hw/pxa_operand_regs.sv
// Pixel ALU operand registers with AHB-Lite slave and per-pixel datapath
//
// Operation
// RULE_01: Pattern 1 uses foreground mix and operand
// RULE_02: Pattern 0 uses background mix and operand
// RULE_03: Compare condition true suppresses destination write
// RULE_04: Codes 000-011: always, greater, equal, less
// RULE_05: Codes 100-111: never, ge, ne, le
// RULE_06: Compare value uses pixel-depth low bits only
// RULE_07: Bits above pixel depth are ignored
// RULE_08: Plane mask bit enables update of bit
// RULE_09: Masked bits excluded from arithmetic and compare
// RULE_10: Carry mask zero stops carry to next
// RULE_11: Carry mask splits pixel into sections
// RULE_12: No carry leaves pixel most significant bit
// RULE_13: Fixed foreground source takes foreground colour
// RULE_14: Fixed background source takes background colour
// RULE_15: Width or length register, count minus one
// RULE_16: Height register, count minus one
// RULE_17: Mask map origin offsets relative to destination
// RULE_18: Source coordinates readable and writable
// RULE_19: Foreground source field bits 29-28 decoded
// RULE_20: Pixel size code selects 1,2,4,8 bits
// RULE_21: Write only unblocked, only plane-enabled bits
// RULE_22: Operand registers hold until rewritten
`default_nettype none
module pxa_operand_regs
    import pxa_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic pix_valid,
    input wire logic pattern_bit,
    input wire logic [31:0] dest_pixel,
    input wire logic [31:0] source_pixel,
    output logic out_valid_r,
    output logic out_write_r,
    output logic [31:0] out_pixel_r,
    output logic [31:0] op_width_or_length_r,
    output logic [31:0] op_height_r,
    output logic [15:0] mask_origin_x_r,
    output logic [15:0] mask_origin_y_r,
    output logic [15:0] source_x_coord_r,
    output logic [15:0] source_y_coord_r
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Sectioned adder: carry gated by mask, none past msb
    function automatic logic [32:0] seg_add(
        input logic [31:0] a,
        input logic [31:0] b,
        input logic cin,
        input logic [31:0] cmask,
        input logic [4:0] msb
    );
        logic [31:0] sum;
        logic c;
        logic co;
        logic top_co;
        sum = 32'h0000_0000;
        c = cin;
        co = 1'b0;
        top_co = 1'b0;
        for (int i = 0; i < 32; i++) begin
            sum[i] = a[i] ^ b[i] ^ c;
            co = (a[i] & b[i]) | (c & (a[i] ^ b[i]));
            if (5'(i) == msb) begin
                top_co = co;
            end
            c = cmask[i] ? co : cin; // RULE_10 RULE_11
            if (5'(i) >= msb) begin
                c = cin; // RULE_12
            end
        end
        return {top_co, sum};
    endfunction

    // Most significant bit index of a pixel
    function automatic logic [4:0] depth_msb(input logic [2:0] code);
        logic [4:0] m;
        unique case (code)
            3'h0: m = 5'h00;
            3'h1: m = 5'h01;
            3'h2: m = 5'h03;
            default: m = 5'h07;
        endcase
        return m; // RULE_20
    endfunction

    // Ones in the active low-order pixel bits
    function automatic logic [31:0] depth_mask(input logic [4:0] msb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 32; i++) begin
            m[i] = (5'(i) <= msb);
        end
        return m;
    endfunction

    // Mix of destination and second operand
    function automatic logic [31:0] mix_fn(
        input logic [7:0] code,
        input logic [31:0] d,
        input logic [31:0] s,
        input logic [31:0] cmask,
        input logic [4:0] msb
    );
        logic [31:0] r;
        logic [32:0] t;
        r = d;
        t = 33'h0_0000_0000;
        if (code[7:4] == MIX_LOGIC_GRP) begin
            for (int i = 0; i < 32; i++) begin
                r[i] = code[{d[i], s[i]}];
            end
        end else if (code == MIX_ADD) begin
            t = seg_add(d, s, 1'b0, cmask, msb);
            r = t[31:0];
        end else if (code == MIX_SUB_DS) begin
            t = seg_add(d, ~s, 1'b1, cmask, msb);
            r = t[31:0];
        end else if (code == MIX_SUB_SD) begin
            t = seg_add(s, ~d, 1'b1, cmask, msb);
            r = t[31:0];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] fg_mix_r;
    logic [7:0] bg_mix_r;
    logic [2:0] cmp_cond_r;
    logic [31:0] cmp_value_r;
    logic [31:0] plane_mask_r;
    logic [31:0] carry_mask_r;
    logic [31:0] fg_colour_r;
    logic [31:0] bg_colour_r;
    logic [31:0] dp_ctrl_r;

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave

    logic wr_pend_r;
    logic [7:0] wr_idx_r;
    logic addr_ok;
    logic take;
    logic rd_take;
    logic fwd_hit;

    assign addr_ok = (haddr[31:ADDR_W] == '0) && (haddr[1:0] == 2'h0);
    assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign rd_take = take && !hwrite && addr_ok;
    assign fwd_hit = wr_pend_r && (wr_idx_r == haddr[ADDR_W-1:2]);
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;

    // Address phase capture
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_pend_r <= 1'b0;
            wr_idx_r <= RST_BYTE;
        end else begin
            wr_pend_r <= take && hwrite && addr_ok;
            if (take) begin
                wr_idx_r <= haddr[ADDR_W-1:2];
            end
        end
    end

    // Write strobe of one register index in its data phase
    function automatic logic wr_hit(input logic [7:0] idx);
        return wr_pend_r && (wr_idx_r == idx);
    endfunction

    // Mix selects
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fg_mix_r <= RST_BYTE;
            bg_mix_r <= RST_BYTE;
        end else begin
            if (wr_hit(IDX_FG_MIX)) begin
                fg_mix_r <= hwdata[7:0]; // RULE_22
            end
            if (wr_hit(IDX_BG_MIX)) begin
                bg_mix_r <= hwdata[7:0]; // RULE_22
            end
        end
    end

    // Compare condition and value
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cmp_cond_r <= CMP_ALWAYS;
            cmp_value_r <= RST_WORD;
        end else begin
            if (wr_hit(IDX_CMP_COND)) begin
                cmp_cond_r <= hwdata[2:0]; // RULE_22
            end
            if (wr_hit(IDX_CMP_VALUE)) begin
                cmp_value_r <= hwdata; // RULE_22
            end
        end
    end

    // Plane and carry masks
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            plane_mask_r <= RST_WORD;
            carry_mask_r <= RST_WORD;
        end else begin
            if (wr_hit(IDX_PLANE_MASK)) begin
                plane_mask_r <= hwdata; // RULE_22
            end
            if (wr_hit(IDX_CARRY_MASK)) begin
                carry_mask_r <= hwdata; // RULE_22
            end
        end
    end

    // Fixed colours
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fg_colour_r <= RST_WORD;
            bg_colour_r <= RST_WORD;
        end else begin
            if (wr_hit(IDX_FG_COLOUR)) begin
                fg_colour_r <= hwdata; // RULE_22
            end
            if (wr_hit(IDX_BG_COLOUR)) begin
                bg_colour_r <= hwdata; // RULE_22
            end
        end
    end

    // Operation size and mask origin
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            op_width_or_length_r <= RST_WORD;
            op_height_r <= RST_WORD;
            mask_origin_x_r <= RST_HALF;
            mask_origin_y_r <= RST_HALF;
        end else begin
            if (wr_hit(IDX_DIM_WIDTH)) begin
                op_width_or_length_r <= hwdata; // RULE_15 RULE_22
            end
            if (wr_hit(IDX_DIM_HEIGHT)) begin
                op_height_r <= hwdata; // RULE_16 RULE_22
            end
            if (wr_hit(IDX_MASK_ORG_X)) begin
                mask_origin_x_r <= hwdata[15:0]; // RULE_17 RULE_22
            end
            if (wr_hit(IDX_MASK_ORG_Y)) begin
                mask_origin_y_r <= hwdata[15:0]; // RULE_17 RULE_22
            end
        end
    end

    // Source coordinates
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            source_x_coord_r <= RST_HALF;
            source_y_coord_r <= RST_HALF;
        end else begin
            if (wr_hit(IDX_SRC_X)) begin
                source_x_coord_r <= hwdata[15:0]; // RULE_18
            end
            if (wr_hit(IDX_SRC_Y)) begin
                source_y_coord_r <= hwdata[15:0]; // RULE_18
            end
        end
    end

    // Datapath control
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dp_ctrl_r <= RST_WORD;
        end else begin
            if (wr_hit(IDX_DP_CTRL)) begin
                dp_ctrl_r <= hwdata; // RULE_22
            end
        end
    end

    // Read word loaded in address phase; landing write forwarded
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hrdata <= RST_WORD;
        end else if (!rd_take) begin
            hrdata <= RST_WORD;
        end else begin
            unique case (haddr[ADDR_W-1:2]) // RULE_18
                IDX_SRC_X: hrdata <= {16'h0000, fwd_hit ? hwdata[15:0] : source_x_coord_r};
                IDX_SRC_Y: hrdata <= {16'h0000, fwd_hit ? hwdata[15:0] : source_y_coord_r};
                IDX_DP_CTRL: hrdata <= fwd_hit ? hwdata : dp_ctrl_r;
                default: hrdata <= RST_WORD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pixel datapath

    logic [4:0] msb;
    logic [31:0] dmask;
    logic [31:0] pmask;
    logic [1:0] fg_sel;
    logic [1:0] bg_sel;
    logic [31:0] fg_op;
    logic [31:0] bg_op;
    logic [31:0] mix_res;
    logic [32:0] cmp_diff;
    logic c_eq;
    logic c_lt;
    logic c_gt;
    logic inhibit;
    logic [31:0] new_pixel;

    assign msb = depth_msb(dp_ctrl_r[PIX_SIZE_LSB +: 3]); // RULE_20
    assign dmask = depth_mask(msb); // RULE_07
    assign pmask = plane_mask_r & dmask; // RULE_08
    assign fg_sel = dp_ctrl_r[FG_SRC_LSB +: 2];
    assign bg_sel = dp_ctrl_r[BG_SRC_LSB +: 2];

    // Operand source selection; reserved codes fall back to colour
    assign fg_op = (fg_sel == SRC_PIXEL_MAP) ? source_pixel : fg_colour_r; // RULE_13 RULE_19
    assign bg_op = (bg_sel == SRC_PIXEL_MAP) ? source_pixel : bg_colour_r; // RULE_14

    // Mix chosen by pattern bit; masked bits zeroed first
    always_comb begin
        if (pattern_bit) begin
            mix_res = mix_fn(fg_mix_r, dest_pixel & pmask, fg_op & pmask,
                             carry_mask_r, msb); // RULE_01 RULE_09
        end else begin
            mix_res = mix_fn(bg_mix_r, dest_pixel & pmask, bg_op & pmask,
                             carry_mask_r, msb); // RULE_02 RULE_09
        end
    end

    // Colour compare on plane-enabled, depth-limited bits
    assign cmp_diff = seg_add(dest_pixel & pmask, ~(cmp_value_r & pmask), 1'b1,
                              carry_mask_r, msb); // RULE_06 RULE_09 RULE_10
    assign c_eq = ((dest_pixel & pmask) == (cmp_value_r & pmask));
    assign c_lt = !cmp_diff[32];
    assign c_gt = !c_lt && !c_eq;

    always_comb begin
        unique case (cmp_cond_r)
            CMP_ALWAYS: inhibit = 1'b1; // RULE_04
            CMP_GT: inhibit = c_gt; // RULE_04
            CMP_EQ: inhibit = c_eq; // RULE_04
            CMP_LT: inhibit = c_lt; // RULE_04
            CMP_NEVER: inhibit = 1'b0; // RULE_05
            CMP_GE: inhibit = c_gt || c_eq; // RULE_05
            CMP_NE: inhibit = !c_eq; // RULE_05
            CMP_LE: inhibit = c_lt || c_eq; // RULE_05
        endcase
    end

    // Only enabled bits replace destination
    assign new_pixel = ((mix_res & pmask) | (dest_pixel & ~pmask)) & dmask; // RULE_21

    // Output stage
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            out_valid_r <= 1'b0;
            out_write_r <= 1'b0;
            out_pixel_r <= RST_WORD;
        end else begin
            out_valid_r <= pix_valid;
            out_write_r <= pix_valid && !inhibit; // RULE_03 RULE_21
            if (pix_valid) begin
                out_pixel_r <= new_pixel;
            end
        end
    end

endmodule
`default_nettype wire

// >>> testbench/pxa_operand_regs_chk.sv
// Checker of register bus and pixel path behaviour
`default_nettype none
module pxa_operand_regs_chk
    import pxa_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic pix_valid,
    input wire logic out_valid_r,
    input wire logic out_write_r,
    input wire logic [31:0] out_pixel_r,
    input wire logic [31:0] op_width_or_length_r,
    input wire logic [31:0] op_height_r,
    input wire logic [15:0] mask_origin_x_r,
    input wire logic [15:0] source_x_coord_r,
    input wire logic [15:0] source_y_coord_r
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic [31:0] hwd_r;
    logic hgt_wr_r;
    always_ff @(posedge ref_clk) begin
        hwd_r <= hwdata;
    end
    always_ff @(posedge ref_clk) begin
        hgt_wr_r <= hsel && hready && htrans[1] && hwrite
            && haddr == {22'h0, IDX_DIM_HEIGHT, 2'h0};
    end
    ////////////////////////////////////////////////////////////////
    sequence s_wr(logic [7:0] i);
        hsel && hready && htrans[1] && hwrite && haddr == {22'h0, i, 2'h0} ##1 1'b1;
    endsequence
    sequence s_rd(logic [7:0] i);
        hsel && hready && htrans[1] && !hwrite && haddr == {22'h0, i, 2'h0} ##1 1'b1;
    endsequence
    property p_pix_ack; pix_valid |=> out_valid_r; endproperty
    a_pix_ack: assert property (p_pix_ack) else $error("pixel not answered");
    property p_idle; !pix_valid |=> !out_valid_r && $stable(out_pixel_r); endproperty
    a_idle: assert property (p_idle) else $error("output moved without pixel");
    property p_wr_valid; out_write_r |-> out_valid_r; endproperty
    a_wr_valid: assert property (p_wr_valid) else $error("write without valid");
    property p_depth; out_valid_r |-> out_pixel_r[31:8] == 24'h0; endproperty
    a_depth: assert property (p_depth) else $error("bits above depth set");
    property p_dim1; s_wr(IDX_DIM_WIDTH) |=> op_width_or_length_r == hwd_r; endproperty
    a_dim1: assert property (p_dim1) else $error("width not stored");
    property p_dim2; s_wr(IDX_DIM_HEIGHT) |=> op_height_r == hwd_r; endproperty
    a_dim2: assert property (p_dim2) else $error("height not stored");
    property p_org; s_wr(IDX_MASK_ORG_X) |=> mask_origin_x_r == hwd_r[15:0]; endproperty
    a_org: assert property (p_org) else $error("mask origin not stored");
    property p_srcy; s_wr(IDX_SRC_Y) |=> source_y_coord_r == hwd_r[15:0]; endproperty
    a_srcy: assert property (p_srcy) else $error("source y not stored");
    property p_src_rd; s_rd(IDX_SRC_X) |-> hrdata[15:0] == source_x_coord_r; endproperty
    a_src_rd: assert property (p_src_rd) else $error("source x read wrong");
    property p_hold; !hgt_wr_r |=> $stable(op_height_r); endproperty
    a_hold: assert property (p_hold) else $error("height changed unwritten");
endmodule
bind pxa_operand_regs pxa_operand_regs_chk u_chk (.ref_clk, .sys_rst, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .pix_valid, .out_valid_r, .out_write_r, .out_pixel_r,
    .op_width_or_length_r, .op_height_r, .mask_origin_x_r, .source_x_coord_r, .source_y_coord_r);
`default_nettype wire

// >>> testbench/pxa_operand_regs_tb.sv
// Self-checking bench for the pixel ALU operand registers
`default_nettype none
module pxa_operand_regs_tb
    import pxa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic pix_valid = 1'b0;
    logic pattern_bit = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, dest_pixel = 32'h0, source_pixel = 32'h0;
    logic hready, hresp, out_valid_r, out_write_r;
    logic [31:0] hrdata, out_pixel_r, op_width_or_length_r, op_height_r, q;
    logic [15:0] mask_origin_x_r, mask_origin_y_r, source_x_coord_r, source_y_coord_r;
    logic [7:0] d8;
    int errors = 0;
    int checks = 0;
    always #50 ref_clk = ~ref_clk;
    pxa_operand_regs u_dut (.ref_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .pix_valid, .pattern_bit,
        .dest_pixel, .source_pixel, .out_valid_r, .out_write_r, .out_pixel_r,
        .op_width_or_length_r, .op_height_r, .mask_origin_x_r, .mask_origin_y_r,
        .source_x_coord_r, .source_y_coord_r);
    ////////////////////////////////////////////////////////////////
    task stop_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task rdy;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            errors++;
            stop_test;
        end
    endtask
    // One single-word transfer, read data in q
    task xf(input logic w, input logic [7:0] i, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {22'h0, i, 2'h0};
        hwrite <= w;
        rdy;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
        q = hrdata;
        chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    endtask
    task px(input logic p, input logic [31:0] d, s, input logic w, input logic [31:0] e);
        pix_valid <= 1'b1;
        pattern_bit <= p;
        dest_pixel <= d;
        source_pixel <= s;
        @(posedge ref_clk);
        pix_valid <= 1'b0;
        @(posedge ref_clk);
        chk("out_valid_r", 32'h1, {31'h0, out_valid_r});
        chk("out_write_r", {31'h0, w}, {31'h0, out_write_r});
        if (w) begin
            chk("out_pixel_r", e, out_pixel_r);
        end
    endtask
    // Inhibit flags indexed by condition code, value 0x50
    function automatic logic hit(int c, logic [7:0] d);
        logic [7:0] t;
        t = {d <= 8'h50, d != 8'h50, d >= 8'h50, 1'b0, d < 8'h50, d == 8'h50, d > 8'h50, 1'b1};
        return t[c];
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        stop_test;
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        xf(1'b1, IDX_DIM_WIDTH, 32'h0000_0FFF);
        xf(1'b1, IDX_DIM_HEIGHT, 32'h0);
        xf(1'b1, IDX_MASK_ORG_X, 32'h0FFF);
        xf(1'b1, IDX_MASK_ORG_Y, 32'h0123);
        xf(1'b1, IDX_SRC_Y, 32'h0FFF);
        xf(1'b1, IDX_SRC_X, 32'h0ABC);
        xf(1'b0, IDX_SRC_X, 32'h0);
        chk("src x read", 32'h0ABC, q);
        chk("width", 32'h0FFF, op_width_or_length_r);
        chk("org y", 32'h0123, {16'h0, mask_origin_y_r});
        chk("src y", 32'h0FFF, {16'h0, source_y_coord_r});
        xf(1'b0, 8'hFF, 32'h0);
        chk("unmapped read", 32'h0, q);
        $display("registers done");
        xf(1'b1, IDX_DP_CTRL, 32'h3);
        xf(1'b1, IDX_PLANE_MASK, 32'hFF);
        xf(1'b1, IDX_CARRY_MASK, 32'hFF);
        xf(1'b1, IDX_FG_MIX, 32'h0A);
        xf(1'b1, IDX_FG_COLOUR, 32'hABCD_EF3C);
        xf(1'b1, IDX_CMP_VALUE, 32'hFFFF_FF50);
        for (int c = 0; c < 8; c++) begin
            xf(1'b1, IDX_CMP_COND, 32'hF8 | 32'(c));
            for (int k = 0; k < 3; k++) begin
                d8 = 8'h4F + 8'(k);
                px(1'b1, {24'h0, d8}, 32'h0, !hit(c, d8), 32'h3C);
            end
        end
        $display("compare done");
        xf(1'b1, IDX_CMP_COND, 32'(CMP_NEVER));
        xf(1'b1, IDX_BG_MIX, 32'h0A);
        xf(1'b1, IDX_BG_COLOUR, 32'h1234_5677);
        px(1'b0, 32'h11, 32'h0, 1'b1, 32'h77);
        px(1'b1, 32'h11, 32'h0, 1'b1, 32'h3C);
        xf(1'b1, IDX_PLANE_MASK, 32'hFFFF_FF0F);
        px(1'b1, 32'hA5, 32'h0, 1'b1, 32'hAC);
        xf(1'b1, IDX_CMP_VALUE, 32'h05);
        xf(1'b1, IDX_CMP_COND, 32'(CMP_EQ));
        px(1'b1, 32'hF5, 32'h0, 1'b0, 32'h0);
        xf(1'b1, IDX_CMP_COND, 32'(CMP_NEVER));
        xf(1'b1, IDX_FG_MIX, 32'(MIX_ADD));
        xf(1'b1, IDX_FG_COLOUR, 32'h01);
        px(1'b1, 32'h1F, 32'h0, 1'b1, 32'h10);
        xf(1'b1, IDX_PLANE_MASK, 32'hFF);
        xf(1'b1, IDX_CARRY_MASK, 32'hF7);
        px(1'b1, 32'h0F, 32'h0, 1'b1, 32'h00);
        px(1'b1, 32'hFF, 32'h0, 1'b1, 32'hF0);
        xf(1'b1, IDX_CARRY_MASK, 32'hFF);
        px(1'b1, 32'hFF, 32'h0, 1'b1, 32'h00);
        xf(1'b1, IDX_FG_MIX, 32'(MIX_SUB_DS));
        px(1'b1, 32'h10, 32'h0, 1'b1, 32'h0F);
        xf(1'b1, IDX_FG_MIX, 32'(MIX_SUB_SD));
        px(1'b1, 32'h02, 32'h0, 1'b1, 32'hFF);
        $display("arithmetic done");
        xf(1'b1, IDX_FG_MIX, 32'h0A);
        xf(1'b1, IDX_DP_CTRL, 32'h2000_0003);
        px(1'b1, 32'h0, 32'h99, 1'b1, 32'h99);
        xf(1'b1, IDX_DP_CTRL, 32'h8000_0003);
        px(1'b0, 32'h0, 32'h66, 1'b1, 32'h66);
        xf(1'b1, IDX_FG_COLOUR, 32'hFFFF_FFFF);
        for (int k = 0; k < 4; k++) begin
            xf(1'b1, IDX_DP_CTRL, 32'(k));
            px(1'b1, 32'h0, 32'h0, 1'b1, (32'h1 << (1 << k)) - 32'h1);
        end
        chk("width held", 32'h0FFF, op_width_or_length_r);
        chk("height held", 32'h0, op_height_r);
        $display("datapath done");
        stop_test;
    end
endmodule
`default_nettype wire
